// ===== core/smhc_core.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module smhc_core (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // modem pins
  input  wire logic        clear_to_send_n,
  input  wire logic        carrier_detect,
  output var  logic        request_to_send_n,
  // channel transmitter side
  input  wire logic        tx_req,
  input  wire logic        tx_char_end,
  input  wire logic        tx_frame_end,
  input  wire logic        tx_pool_free,
  input  wire logic        tx_data,
  output var  logic        tx_enable,
  output var  logic        tx_abort,
  output var  logic        tx_retransmit,
  output var  logic        tx_reset,
  output var  logic        serial_out,
  output var  logic        transmit_repeat_event,
  // channel receiver side
  input  wire logic        rx_frame_active,
  input  wire logic        rx_char_end,
  input  wire logic        serial_in,
  output var  logic        rx_enable,
  output var  logic        rx_data,
  // interrupt
  output var  logic        irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]      cts_sync;
    logic [1:0]      cd_sync;
    logic            cts_prev;
    logic [7:0]      cfg_a;
    logic [7:0]      cfg_b;
    logic [7:0]      cfg_c;
    logic [7:0]      mode;
    logic [7:0]      bch;
    logic [7:0]      mask_one;
    logic [7:0]      mask_two;
    logic [1:0]      status_two;
    smhc_pkg::smhc_tx_t tx_state;
    logic            pool_gone;
    logic            rx_run;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            rts_n;
    logic            tx_en;
    logic            abort;
    logic            retx;
    logic            txrst;
    logic            repeat_ev;
    logic            sout;
    logic            rdat;
    logic            irq;
  } smhc_state_t;

  smhc_state_t st;
  smhc_state_t next_st;

  // decoded controls from registers
  logic       cts_ok;
  logic       cd_hi;
  logic       powered;
  logic       sync_mode;
  logic [2:0] clk_mode;
  logic [1:0] rts_sel;
  logic       special_ok;
  logic       cas_ok;
  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] int_bits;
  logic [31:0] rd_word;
  logic       rd_hit;
  logic       wr_hit;
  logic       rts_auto_n;

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb begin
    cts_ok     = ~st.cts_sync[1];
    cd_hi      = st.cd_sync[1];
    powered    = st.cfg_a[smhc_pkg::CFGA_POWER_UP];
    sync_mode  = st.cfg_a[smhc_pkg::CFGA_MODE_LO +: 2]
                 != smhc_pkg::SMODE_ASYNC;
    clk_mode   = st.cfg_b[smhc_pkg::CFGB_CLKMODE_LO +: 3];
    rts_sel    = {st.cfg_c[smhc_pkg::CFGC_SEL_HI],
                  st.cfg_c[smhc_pkg::CFGC_SEL_LO]};
    // bus config plus clock mode 0 or 1 only
    special_ok = st.cfg_a[smhc_pkg::CFGA_BUS_CONFIG]
                 && (clk_mode <= smhc_pkg::CLKMODE_ONE);
    // mode 5 lies outside the listed set, mode 1 excluded
    cas_ok     = st.bch[smhc_pkg::BCH_CAS]
                 && clk_mode != smhc_pkg::CLKMODE_ONE
                 && clk_mode != smhc_pkg::CLKMODE_FIVE;
    wr_fire    = st.aw_got && st.w_got && !st.bvalid;
    rd_fire    = s_axi_arvalid && st.arready;
    int_bits   = {6'h00, st.status_two} & ~st.mask_two;
    rts_auto_n = ~(tx_req || st.tx_state != smhc_pkg::SMHC_TX_IDLE);
  end

  // register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      smhc_pkg::ADDR_CHANNEL_CONFIG_A: rd_word[7:0] = st.cfg_a;
      smhc_pkg::ADDR_CHANNEL_CONFIG_B: rd_word[7:0] = st.cfg_b;
      smhc_pkg::ADDR_CHANNEL_CONFIG_C: rd_word[7:0] = st.cfg_c;
      smhc_pkg::ADDR_MODE:             rd_word[7:0] = st.mode;
      smhc_pkg::ADDR_BYTE_COUNT_HIGH:  rd_word[7:0] = st.bch;
      smhc_pkg::ADDR_MASK_ONE:         rd_word[7:0] = st.mask_one;
      smhc_pkg::ADDR_MASK_TWO:         rd_word[7:0] = st.mask_two;
      smhc_pkg::ADDR_STATUS_TWO:       rd_word[1:0] = st.status_two;
      smhc_pkg::ADDR_CHANNEL_STATE: begin
        rd_word[4:0] = {st.rx_run, cd_hi, cts_ok, st.tx_state};
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign wr_hit = (st.aw_addr <= smhc_pkg::ADDR_STATUS_TWO)
                  && (st.aw_addr[1:0] == 2'b00);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // synchronisers: stage 0 feeds stage 1 only
    next_st.cts_sync = {st.cts_sync[0], clear_to_send_n};
    next_st.cd_sync  = {st.cd_sync[0], carrier_detect};
    next_st.cts_prev = st.cts_sync[1];
    next_st.abort    = 1'b0;
    next_st.retx     = 1'b0;
    next_st.txrst    = 1'b0;
    next_st.repeat_ev = 1'b0;

    // axi write channel capture, either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (wr_fire) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_hit ? smhc_pkg::RESP_OKAY
                              : smhc_pkg::RESP_SLVERR;
      if (st.w_strb[0]) begin
        case (st.aw_addr)
          smhc_pkg::ADDR_CHANNEL_CONFIG_A: next_st.cfg_a = st.w_data[7:0];
          smhc_pkg::ADDR_CHANNEL_CONFIG_B: next_st.cfg_b = st.w_data[7:0];
          smhc_pkg::ADDR_CHANNEL_CONFIG_C: next_st.cfg_c = st.w_data[7:0];
          smhc_pkg::ADDR_MODE:             next_st.mode  = st.w_data[7:0];
          smhc_pkg::ADDR_BYTE_COUNT_HIGH:  next_st.bch   = st.w_data[7:0];
          smhc_pkg::ADDR_MASK_ONE:      next_st.mask_one = st.w_data[7:0];
          smhc_pkg::ADDR_MASK_TWO:      next_st.mask_two = st.w_data[7:0];
          // write one to clear
          smhc_pkg::ADDR_STATUS_TWO: begin
            next_st.status_two = st.status_two & ~st.w_data[1:0];
          end
          default: next_st.bresp = smhc_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.aw_got  = 1'b0;
      next_st.w_got   = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // axi read: one cycle from address to data
    if (rd_fire) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_word;
      next_st.rresp   = rd_hit ? smhc_pkg::RESP_OKAY
                               : smhc_pkg::RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // handshake change: edges counted even when powered down
    if (st.cts_sync[1] != st.cts_prev) begin
      next_st.status_two[smhc_pkg::ST_HANDSHAKE] = 1'b1;
    end

    // transmitter control, frozen while powered down
    if (powered) begin
      case (st.tx_state)
        smhc_pkg::SMHC_TX_IDLE: begin
          if (tx_req && cts_ok) begin
            next_st.tx_state  = smhc_pkg::SMHC_TX_SEND;
            next_st.pool_gone = 1'b0;
          end
        end
        smhc_pkg::SMHC_TX_SEND: begin
          if (tx_pool_free) begin
            next_st.pool_gone = 1'b1;
          end
          if (tx_frame_end || (!sync_mode && tx_char_end && !tx_req)) begin
            next_st.tx_state = smhc_pkg::SMHC_TX_IDLE;
          end else if (!cts_ok && !sync_mode) begin
            // async waits for the character boundary
            if (tx_char_end) begin
              next_st.tx_state = smhc_pkg::SMHC_TX_HOLD;
            end
          end else if (!cts_ok && st.pool_gone) begin
            // start of frame lost, software must repeat it
            next_st.tx_state  = smhc_pkg::SMHC_TX_IDLE;
            next_st.txrst     = 1'b1;
            next_st.repeat_ev = 1'b1;
            next_st.status_two[smhc_pkg::ST_REPEAT] = 1'b1;
          end else if (!cts_ok) begin
            next_st.tx_state = smhc_pkg::SMHC_TX_HOLD;
            next_st.abort    = 1'b1;
          end
        end
        smhc_pkg::SMHC_TX_HOLD: begin
          if (cts_ok) begin
            next_st.tx_state = smhc_pkg::SMHC_TX_SEND;
            next_st.retx     = sync_mode;
          end
        end
        default: next_st.tx_state = smhc_pkg::SMHC_TX_IDLE;
      endcase

      // receiver auto start; stop on a character boundary or when no frame is active
      if (cas_ok) begin
        if (cd_hi) begin
          next_st.rx_run = 1'b1;
        end else if (rx_char_end || !rx_frame_active) begin
          next_st.rx_run = 1'b0;
        end
      end else begin
        next_st.rx_run = st.mode[smhc_pkg::MODE_RX_ACTIVE] == 1'b0;
      end
    end

    // request-to-send pin
    if (special_ok && rts_sel == smhc_pkg::SEL_DISABLED) begin
      next_st.rts_n = 1'b1;
    end else if (special_ok && rts_sel == smhc_pkg::SEL_RX_FRAME) begin
      next_st.rts_n = ~rx_frame_active;
    end else if (st.mode[smhc_pkg::MODE_RTS_SW]) begin
      next_st.rts_n = st.mode[smhc_pkg::MODE_RTS_LEVEL];
    end else if (next_st.txrst) begin
      next_st.rts_n = 1'b1;
    end else begin
      next_st.rts_n = rts_auto_n;
    end

    next_st.tx_en = powered && next_st.tx_state == smhc_pkg::SMHC_TX_SEND;
    // idle is a mark while not sending
    next_st.sout  = next_st.tx_en ? tx_data : 1'b1;
    // loopback returns our own line
    next_st.rdat  = st.mode[smhc_pkg::MODE_LOOPBACK] ? st.sout
                                                     : serial_in;
    // power-down forwards nothing
    next_st.irq   = powered && (int_bits != 8'h00);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st            <= '0;
      st.cts_sync   <= 2'b11;
      st.cd_sync    <= 2'b00;
      st.cts_prev   <= 1'b1;
      st.cfg_c      <= smhc_pkg::RST_ZERO;
      st.mode       <= smhc_pkg::RST_ZERO;
      st.bch        <= smhc_pkg::RST_ZERO;
      st.mask_one   <= smhc_pkg::RST_MASK;
      st.mask_two   <= smhc_pkg::RST_MASK;
      st.tx_state   <= smhc_pkg::SMHC_TX_IDLE;
      st.awready    <= 1'b1;
      st.wready     <= 1'b1;
      st.arready    <= 1'b1;
      st.rts_n      <= 1'b1;
      st.sout       <= 1'b1;
      st.rdat       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready         = st.awready;
  assign s_axi_wready          = st.wready;
  assign s_axi_bvalid          = st.bvalid;
  assign s_axi_bresp           = st.bresp;
  assign s_axi_arready         = st.arready;
  assign s_axi_rvalid          = st.rvalid;
  assign s_axi_rdata           = st.rdata;
  assign s_axi_rresp           = st.rresp;
  assign request_to_send_n     = st.rts_n;
  assign tx_enable             = st.tx_en;
  assign tx_abort              = st.abort;
  assign tx_retransmit         = st.retx;
  assign tx_reset              = st.txrst;
  assign transmit_repeat_event = st.repeat_ev;
  assign serial_out            = st.sout;
  assign rx_enable             = st.rx_run;
  assign rx_data               = st.rdat;
  assign irq                   = st.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cts_lost_sync;
    powered && sync_mode && st.tx_state == smhc_pkg::SMHC_TX_SEND
    && !cts_ok && !st.pool_gone && !tx_frame_end;
  endsequence

  a_tx_needs_cts: assert property (
    $rose(tx_enable) |-> $past(cts_ok))
    else $error("transmit started without clear-to-send");
  a_sync_abort: assert property (
    s_cts_lost_sync |=> tx_abort && !tx_enable)
    else $error("sync frame not aborted on clear-to-send loss");
  a_retx_on_cts: assert property (
    st.tx_state == smhc_pkg::SMHC_TX_HOLD && cts_ok && sync_mode
    && powered |=> tx_retransmit ##1 !tx_retransmit)
    else $error("no retransmit on clear-to-send return");
  // software or a special rts function may own the pin meanwhile
  a_repeat_event: assert property (
    transmit_repeat_event |-> tx_reset
    && st.status_two[smhc_pkg::ST_REPEAT]
    && (request_to_send_n
        || $past(st.mode[smhc_pkg::MODE_RTS_SW] || special_ok)))
    else $error("repeat event without reset and rts high");
  a_cts_flag: assert property (
    st.cts_sync[1] != st.cts_prev
    |=> st.status_two[smhc_pkg::ST_HANDSHAKE])
    else $error("clear-to-send edge not flagged");
  a_rts_disabled: assert property (
    special_ok && rts_sel == smhc_pkg::SEL_DISABLED
    ##1 $stable(st.cfg_c) && $stable(st.cfg_a) && $stable(st.cfg_b)
    |-> request_to_send_n)
    else $error("rts not high with function disabled");
  a_no_cd_mode1: assert property (
    clk_mode == smhc_pkg::CLKMODE_ONE |-> !cas_ok)
    else $error("carrier control active in clock mode 1");
  a_loopback: assert property (
    st.mode[smhc_pkg::MODE_LOOPBACK] && $stable(st.mode)
    |=> rx_data == $past(serial_out))
    else $error("loopback not returning transmit line");
  a_powerdown_irq: assert property (
    !powered |=> !irq)
    else $error("interrupt forwarded in power-down");
endmodule
`default_nettype wire

// ===== core/smhc_pkg.sv
package smhc_pkg;
  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_CHANNEL_CONFIG_A = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL_CONFIG_B = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL_CONFIG_C = 8'h08;
  localparam logic [7:0] ADDR_MODE             = 8'h0C;
  localparam logic [7:0] ADDR_BYTE_COUNT_HIGH  = 8'h10;
  localparam logic [7:0] ADDR_MASK_ONE         = 8'h14;
  localparam logic [7:0] ADDR_MASK_TWO         = 8'h18;
  localparam logic [7:0] ADDR_STATUS_TWO       = 8'h1C;
  localparam logic [7:0] ADDR_CHANNEL_STATE    = 8'h20;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFGA_POWER_UP   = 7;   // channel_config_a
  localparam int CFGA_BUS_CONFIG = 6;
  localparam int CFGA_MODE_LO    = 0;   // serial mode, 2 bits
  localparam int CFGB_CLKMODE_LO = 0;   // clock mode, 3 bits
  localparam int CFGC_SEL_HI     = 7;   // rts_function_select_hi
  localparam int CFGC_SEL_LO     = 6;   // rts_function_select_lo
  localparam int MODE_RX_ACTIVE  = 3;
  localparam int MODE_RTS_SW     = 2;   // software owns request-to-send
  localparam int MODE_RTS_LEVEL  = 1;
  localparam int MODE_LOOPBACK   = 0;   // loopback_test_bit
  localparam int BCH_CAS         = 2;   // carrier-detect auto start
  localparam int ST_HANDSHAKE    = 1;   // handshake_change_flag
  localparam int ST_REPEAT       = 0;   // transmit_repeat_event

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [1:0] SEL_RX_FRAME = 2'h3;
  localparam logic [1:0] SEL_DISABLED = 2'h2;
  localparam logic [1:0] SMODE_ASYNC  = 2'h2;
  localparam logic [2:0] CLKMODE_ONE  = 3'h1;
  localparam logic [2:0] CLKMODE_FIVE = 3'h5;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ      = 100;
  localparam int RESET_MIN_US = 5;
  localparam int RESET_CYCLES = RESET_MIN_US * CLK_MHZ;

  // transmitter state
  typedef enum logic [1:0] {
    SMHC_TX_IDLE  = 2'b00,
    SMHC_TX_SEND  = 2'b01,
    SMHC_TX_HOLD  = 2'b10
  } smhc_tx_t;

  // transmitter side status from the channel
  typedef struct packed {
    logic req;       // frame or character waiting
    logic char_end;  // character boundary on the line
    logic frame_end; // frame fully sent
    logic pool_free; // first pool sent and released
  } smhc_txin_t;
endpackage

// ===== verification/serial_modem_handshake_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_modem_handshake_control_test;
  // ********************
  // pins and bookkeeping
  // ********************
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        clear_to_send_n, carrier_detect, request_to_send_n;
  logic        tx_enable, serial_out, rx_enable, rx_data, irq;
  logic        tx_req = 1'h0, tx_pool_free = 1'h0, tx_data = 1'h0;
  logic        serial_in = 1'h1, hold = 1'h1, free = 1'h0;
  logic        carrier = 1'h0, clr = 1'h1;
  logic        tx_char_end = 1'h0, rx_frame_active = 1'h0;
  logic        tx_abort, tx_retransmit, tx_reset, transmit_repeat_event;
  logic [4:0]  saw;
  int          n_errors = 0, checked = 0;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] v;
    logic [1:0] r;
  } smhc_row_t;
  smhc_row_t   rows [9];
  always #5 aclk = ~aclk;
  // one-cycle pulses are latched so a later look cannot miss them
  always @(posedge aclk)
    saw <= clr ? 5'h00 : saw | {request_to_send_n, transmit_repeat_event,
                                tx_reset, tx_retransmit, tx_abort};
  // byte lanes and two quiet boundary inputs stay tied
  smhc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clear_to_send_n,
    .carrier_detect, .request_to_send_n, .tx_req, .tx_char_end,
    .tx_frame_end(1'h0), .tx_pool_free, .tx_data, .tx_enable, .tx_abort,
    .tx_retransmit, .tx_reset, .serial_out, .transmit_repeat_event,
    .rx_frame_active, .rx_char_end(1'h0), .serial_in, .rx_enable,
    .rx_data, .irq);
  smhc_modem #(.DELAY(3)) modem (.aclk, .aresetn, .withhold(hold),
    .free_run(free), .carrier_on(carrier), .request_to_send_n,
    .clear_to_send_n, .carrier_detect);
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // fixed wait: pin sync, modem delay and status update all fit in it
  task automatic gap;
    repeat (12) @(posedge aclk);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    rows = '{'{8'h00, 8'h00, 2'h0}, '{8'h04, 8'h00, 2'h0},
      '{8'h08, 8'h00, 2'h0}, '{8'h0C, 8'h00, 2'h0}, '{8'h10, 8'h00, 2'h0},
      '{8'h14, 8'hFF, 2'h0}, '{8'h18, 8'hFF, 2'h0}, '{8'h1C, 8'h00, 2'h0},
      '{8'h24, 8'h00, smhc_pkg::RESP_SLVERR}};
    // synchronous reset: one edge would do, twenty are held
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values, then an unmapped word
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(d, {24'h0, rows[i].v});
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    // clock mode first, then power-up with a waiting frame
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_B, 32'h0);
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_A, 32'h80);
    tx_req <= 1'h1;
    gap;
    chk(32'(request_to_send_n), 32'h0);
    chk(32'(tx_enable), 32'h0);
    hold <= 1'h0;
    gap;
    chk(32'(tx_enable), 32'h1);
    rd(smhc_pkg::ADDR_STATUS_TWO);
    chk(32'(d[1]), 32'h1);
    chk(32'(irq), 32'h0);
    wr(smhc_pkg::ADDR_MASK_TWO, 32'h0);
    gap;
    chk(32'(irq), 32'h1);
    // grant lost mid-frame, then restored
    clr <= 1'h0;
    hold <= 1'h1;
    gap;
    chk(32'(serial_out), 32'h1);
    chk(32'(saw[0]), 32'h1);
    hold <= 1'h0;
    gap;
    chk(32'(saw[1]), 32'h1);
    // loss after the first pool is gone cannot recover by itself
    clr <= 1'h1;
    tx_pool_free <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    tx_pool_free <= 1'h0;
    hold <= 1'h1;
    gap;
    chk({29'h0, saw[4:2]}, 32'h7);
    rd(smhc_pkg::ADDR_STATUS_TWO);
    chk(32'(d[0]), 32'h1);
    // frame dropped; the request is withdrawn and the modem may grant again
    tx_req <= 1'h0;
    hold <= 1'h0;
    // software owns the request line
    wr(smhc_pkg::ADDR_MODE, 32'h4);
    gap;
    chk(32'(request_to_send_n), 32'h0);
    wr(smhc_pkg::ADDR_MODE, 32'h6);
    gap;
    chk(32'(request_to_send_n), 32'h1);
    // loopback hears the idle transmitter, not the pin
    tx_data <= 1'h1;
    serial_in <= 1'h0;
    wr(smhc_pkg::ADDR_MODE, 32'h1);
    gap;
    chk(32'(rx_data), 32'h1);
    wr(smhc_pkg::ADDR_MODE, 32'h0);
    gap;
    chk(32'(rx_data), 32'h0);
    // bus configuration with the request line disabled
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_A, 32'hC0);
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_C, 32'h80);
    tx_req <= 1'h1;
    free <= 1'h1;
    gap;
    chk(32'(request_to_send_n), 32'h1);
    chk(32'(tx_enable), 32'h1);
    // request line marks frame reception only
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_C, 32'hC0);
    rx_frame_active <= 1'h1;
    gap;
    chk(32'(request_to_send_n), 32'h0);
    rx_frame_active <= 1'h0;
    gap;
    chk(32'(request_to_send_n), 32'h1);
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_A, 32'h80);
    gap;
    chk(32'(request_to_send_n), 32'h0);
    tx_req <= 1'h0;
    // receiver off unless the carrier starts it
    wr(smhc_pkg::ADDR_MODE, 32'h8);
    wr(smhc_pkg::ADDR_BYTE_COUNT_HIGH, 32'h4);
    carrier <= 1'h1;
    gap;
    chk(32'(rx_enable), 32'h1);
    // carrier lost mid-character: receiver keeps running
    rx_frame_active <= 1'h1;
    carrier <= 1'h0;
    gap;
    chk(32'(rx_enable), 32'h1);
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_B, 32'h1);
    gap;
    chk(32'(rx_enable), 32'h0);
    // async: the character on the line ends first, no abort, no retransmit
    tx_req <= 1'h1;
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_A, 32'h82);
    clr <= 1'h1;
    hold <= 1'h1;
    gap;
    chk(32'(tx_enable), 32'h1);
    clr <= 1'h0;
    tx_char_end <= 1'h1;
    @(posedge aclk);
    tx_char_end <= 1'h0;
    gap;
    chk(32'(tx_enable), 32'h0);
    hold <= 1'h0;
    gap;
    chk(32'(tx_enable), 32'h1);
    chk({30'h0, saw[1:0]}, 32'h0);
    // power-down keeps registers and silences the interrupt
    wr(smhc_pkg::ADDR_CHANNEL_CONFIG_A, 32'h0);
    wr(smhc_pkg::ADDR_STATUS_TWO, 32'h3);
    hold <= 1'h1;
    gap;
    rd(smhc_pkg::ADDR_STATUS_TWO);
    chk(32'(d[1]), 32'h1);
    chk(32'(irq), 32'h0);
    rd(smhc_pkg::ADDR_MASK_TWO);
    chk(d, 32'h0);
    end_sim;
  end
  // hang guard, far beyond the length of the sequence
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire

// ===== verification/smhc_modem.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// modem partner
// ********************
module smhc_modem #(
  parameter int DELAY = 3
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // bench commands
  input  wire logic withhold,
  input  wire logic free_run,
  input  wire logic carrier_on,
  // handshake lines
  input  wire logic request_to_send_n,
  output var  logic clear_to_send_n,
  output var  logic carrier_detect
);
  int cnt;
  initial clear_to_send_n = 1'h1;
  initial carrier_detect = 1'h0;
  // grant only after a delay, withdraw at once as a real modem may
  always @(posedge aclk) begin
    carrier_detect <= carrier_on & aresetn;
    if (!aresetn || withhold || (request_to_send_n && !free_run)) begin
      cnt <= 0;
      clear_to_send_n <= 1'h1;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      clear_to_send_n <= 1'h0;
    end
  end
endmodule
`default_nettype wire
